// ---- verilog/pcmd_pkg.sv ----
// Purpose : Shared constants for the packet checksum and start delay block
// Assumes : 50 MHz core clock, classic Wishbone register access
// Notes   : Register offsets are word indexes; byte address is index * 4
package pcmd_pkg;

  // ==========================================================================
  // Register word indexes
  localparam logic [11:0] PCMD_IDX_PKT_OPT   = 12'h108;
  localparam logic [11:0] PCMD_IDX_RX_DELAY  = 12'h109;
  localparam logic [11:0] PCMD_IDX_TX_DELAY  = 12'h10A;
  localparam logic [11:0] PCMD_IDX_BUF_CFG   = 12'h107;
  localparam logic [11:0] PCMD_IDX_DELAY_EXT = 12'h10B;
  localparam logic [11:0] PCMD_IDX_MODE      = 12'h13E;
  localparam logic [11:0] PCMD_IDX_IRQ_STAT  = 12'h180;
  localparam logic [11:0] PCMD_IDX_IRQ_CLR   = 12'h181;
  localparam logic [11:0] PCMD_IDX_IRQ_EN    = 12'h182;
  localparam logic [11:0] PCMD_IDX_STATUS    = 12'h183;

  // ==========================================================================
  // Field positions
  localparam int PCMD_BIT_ADDON      = 4;
  localparam int PCMD_BIT_SYNT_SKIP  = 3;
  localparam int PCMD_BIT_FCS_OFF    = 0;
  localparam int PCMD_BIT_DELAY_DIS  = 7;
  localparam int PCMD_IRQ_FRAME_RCVD = 0;
  localparam int PCMD_IRQ_RX_READY   = 1;
  localparam int PCMD_IRQ_TX_READY   = 2;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] PCMD_RST_PKT_OPT   = 8'h04;
  localparam logic [7:0] PCMD_RST_RX_DELAY  = 8'hC0;
  localparam logic [7:0] PCMD_RST_TX_DELAY  = 8'hC0;
  localparam logic [7:0] PCMD_RST_BUF_CFG   = 8'h00;
  localparam logic [7:0] PCMD_RST_DELAY_EXT = 8'h00;
  localparam logic [7:0] PCMD_RST_MODE      = 8'h00;

  // ==========================================================================
  // Packet formats
  localparam logic [7:0] PCMD_MODE_IEEE     = 8'h00;
  localparam logic [7:0] PCMD_MODE_FSK_PKT  = 8'h04;

  // ==========================================================================
  // Timing
  localparam int PCMD_CLK_HZ        = 50_000_000;
  localparam int PCMD_STEP_NS       = 1000;
  localparam int PCMD_CYC_PER_US    = PCMD_CLK_HZ / 1_000_000;
  localparam int PCMD_EXT_US        = 4;
  localparam int PCMD_SYNT_SETTLE_US = 32;

endpackage : pcmd_pkg

// ---- verilog/pcmd_top.sv ----
// Purpose : Checksum handling, add-on enable, synthesizer bypass and
//           programmable receive/transmit start delays of a packet manager
// Assumes : Single core clock; commands arrive as one-cycle pulses from
//           logic on the same clock; Wishbone classic slave, 32-bit data
// Notes   : Ack comes one cycle after the request is seen, one per access
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Synthesizer bypass bit skips calibration and settling
// - Frame received raises interrupt in packet modes
// - IEEE receive validates FCS, stores RSSI/quality
// - IEEE transmit appends computed FCS
// - IEEE checksum off passes FCS unchanged
// - FSK receive validates CRC, transmit appends
// - FSK checksum off passes CRC unchanged
// - IEEE receive waits delay before SFD search
// - FSK receive waits delay before sync search
// - Transmit waits programmed delay before TX state
// - Delay-disable bit bypasses both delays
// - Extension adds four microsecond steps
module pcmd_top
  import pcmd_pkg::*;
#(
  parameter int CLK_HZ = PCMD_CLK_HZ  // Core clock rate
)(
  input  wire logic        core_clk,       // Core clock
  input  wire logic        arst_n,         // Async reset, active low
  input  wire logic        wb_cyc_i,       // Wishbone cycle
  input  wire logic        wb_stb_i,       // Wishbone strobe
  input  wire logic        wb_we_i,        // Wishbone write enable
  input  wire logic [13:0] wb_adr_i,       // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,       // Wishbone byte selects
  input  wire logic [31:0] wb_dat_i,       // Wishbone write data
  output var  logic [31:0] wb_dat_o,       // Wishbone read data
  output var  logic        wb_ack_o,       // Wishbone acknowledge
  input  wire logic        cmdEnterReceive,  // Receive command pulse
  input  wire logic        cmdEnterTransmit, // Transmit command pulse
  input  wire logic        frameDone,      // Frame reception finished
  input  wire logic        chkValid,       // Received checksum matched
  output var  logic        searchStart,    // Pulse: start SFD/sync search
  output var  logic        rssiWindowOpen, // Level: RSSI window open
  output var  logic        txEnter,        // Pulse: enter transmit state
  output var  logic        syntCalRun,     // Level: synth calibration
  output var  logic        addonEnable,    // Level: add-on module enabled
  output var  logic        autoChkRx,      // Level: validate rx checksum
  output var  logic        autoChkTx,      // Level: append tx checksum
  output var  logic        storeRssiQuality, // Level: quality over FCS
  output var  logic        frameRcvdOk,    // Pulse: frame with good check or check off
  output var  logic        irq             // Interrupt, active high
);

  localparam int CYC_US  = CLK_HZ / 1_000_000;
  localparam int SETTLE  = PCMD_SYNT_SETTLE_US * PCMD_STEP_NS / PCMD_STEP_NS;

  typedef enum logic [1:0] {IDLE, SETTLE_ST, WAIT_ST} pcmd_state_e;

  typedef struct packed {
    logic [7:0]  pktOpt;
    logic [7:0]  rxDelay;
    logic [7:0]  txDelay;
    logic [7:0]  bufCfg;
    logic [7:0]  delayExt;
    logic [7:0]  mode;
    logic [2:0]  irqStat;
    logic [2:0]  irqEn;
    logic [7:0]  preCnt;
    logic [10:0] usCnt;
    logic        isTx;
    pcmd_state_e state;
    logic [31:0] datOut;
    logic        ack;
    logic        search;
    logic        rssiWin;
    logic        txGo;
    logic        synt;
    logic        frameOk;
    logic        irqOut;
    logic        chkOn;
    logic        storeRs;
  } pcmd_state_s;

  pcmd_state_s s_q;
  pcmd_state_s s_d;

  logic [11:0] idx;
  logic        usTick;
  logic        isIeee;
  logic        isPkt;
  logic        wbReq;
  logic [2:0]  evts;
  logic [10:0] delayUs;

  // ==========================================================================
  // Decode helpers
  assign idx    = wb_adr_i[13:2];
  assign wbReq  = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign usTick = (s_q.preCnt == 8'(CYC_US - 1));
  assign isIeee = (s_q.mode == PCMD_MODE_IEEE);
  assign isPkt  = isIeee || (s_q.mode == PCMD_MODE_FSK_PKT);

  // Base delay plus extension in 4 us steps
  assign delayUs = (s_q.isTx ? {3'h0, s_q.txDelay} : {3'h0, s_q.rxDelay})
                 + {1'b0, s_q.delayExt, 2'h0};

  // ==========================================================================
  // Next-state logic
  always_comb
  begin
    s_d         = s_q;
    s_d.ack     = wbReq;
    s_d.search  = 1'b0;
    s_d.txGo    = 1'b0;
    s_d.frameOk = 1'b0;
    evts        = 3'h0;

    // Microsecond prescaler, restarted with each accepted command; a
    // command that arrives while busy is dropped and must not shift the
    // tick phase, or the running delay would stretch by up to one step
    if (usTick || (s_q.state == IDLE &&
                   (cmdEnterReceive || cmdEnterTransmit)))
      s_d.preCnt = 8'h00;
    else
      s_d.preCnt = s_q.preCnt + 8'h01;

    // Frame reception, checked only when validation is active
    if (frameDone && isPkt)
    begin
      evts[PCMD_IRQ_FRAME_RCVD] = 1'b1;
      s_d.frameOk = s_q.pktOpt[PCMD_BIT_FCS_OFF] || chkValid;
      s_d.rssiWin = 1'b0;
    end

    // Command sequencer: settle phase, then start delay
    case (s_q.state)
      IDLE:
      begin
        if (cmdEnterReceive || cmdEnterTransmit)
        begin
          s_d.isTx    = cmdEnterTransmit;
          s_d.usCnt   = 11'h000;
          s_d.rssiWin = 1'b0;
          if (!s_q.pktOpt[PCMD_BIT_SYNT_SKIP])
          begin
            s_d.synt  = 1'b1;
            s_d.state = SETTLE_ST;
          end
          else
            s_d.state = WAIT_ST;
        end
      end
      SETTLE_ST:
      begin
        if (usTick)
          s_d.usCnt = s_q.usCnt + 11'h001;
        if (usTick && s_q.usCnt == 11'(SETTLE - 1))
        begin
          s_d.synt  = 1'b0;
          s_d.usCnt = 11'h000;
          s_d.state = WAIT_ST;
        end
      end
      WAIT_ST:
      begin
        if (usTick)
          s_d.usCnt = s_q.usCnt + 11'h001;
        if (s_q.bufCfg[PCMD_BIT_DELAY_DIS] || s_q.usCnt >= delayUs)
        begin
          s_d.state = IDLE;
          if (s_q.isTx)
          begin
            s_d.txGo = 1'b1;
            evts[PCMD_IRQ_TX_READY] = 1'b1;
          end
          else
          begin
            s_d.search  = 1'b1;
            s_d.rssiWin = isIeee;
            evts[PCMD_IRQ_RX_READY] = 1'b1;
          end
        end
      end
      default:
        s_d.state = IDLE;
    endcase

    // Register writes, byte lane 0 carries the 8-bit registers
    if (wbReq && wb_we_i && wb_sel_i[0])
    begin
      case (idx)
        PCMD_IDX_PKT_OPT:   s_d.pktOpt   = wb_dat_i[7:0];
        PCMD_IDX_RX_DELAY:  s_d.rxDelay  = wb_dat_i[7:0];
        PCMD_IDX_TX_DELAY:  s_d.txDelay  = wb_dat_i[7:0];
        PCMD_IDX_BUF_CFG:   s_d.bufCfg   = wb_dat_i[7:0];
        PCMD_IDX_DELAY_EXT: s_d.delayExt = wb_dat_i[7:0];
        PCMD_IDX_MODE:      s_d.mode     = wb_dat_i[7:0];
        PCMD_IDX_IRQ_EN:    s_d.irqEn    = wb_dat_i[2:0];
        PCMD_IDX_IRQ_CLR:   s_d.irqStat  = s_q.irqStat & ~wb_dat_i[2:0];
        default: ;
      endcase
    end
    // Events win over a clear in the same cycle
    s_d.irqStat = s_d.irqStat | evts;

    // Register reads; unmapped reads return zero
    s_d.datOut = 32'h0000_0000;
    if (wbReq && !wb_we_i)
    begin
      case (idx)
        PCMD_IDX_PKT_OPT:   s_d.datOut[7:0] = s_q.pktOpt;
        PCMD_IDX_RX_DELAY:  s_d.datOut[7:0] = s_q.rxDelay;
        PCMD_IDX_TX_DELAY:  s_d.datOut[7:0] = s_q.txDelay;
        PCMD_IDX_BUF_CFG:   s_d.datOut[7:0] = s_q.bufCfg;
        PCMD_IDX_DELAY_EXT: s_d.datOut[7:0] = s_q.delayExt;
        PCMD_IDX_MODE:      s_d.datOut[7:0] = s_q.mode;
        PCMD_IDX_IRQ_STAT:  s_d.datOut[2:0] = s_q.irqStat;
        PCMD_IDX_IRQ_EN:    s_d.datOut[2:0] = s_q.irqEn;
        PCMD_IDX_STATUS:    s_d.datOut[3:0] = {s_q.isTx, s_q.synt,
                                               2'(s_q.state)};
        default: ;
      endcase
    end

    s_d.irqOut = |(s_d.irqStat & s_d.irqEn);

    // Checksum handling follows the options as just written, so the
    // level outputs change in the same cycle as the register itself
    s_d.chkOn   = !s_d.pktOpt[PCMD_BIT_FCS_OFF];
    s_d.storeRs = s_d.chkOn && (s_d.mode == PCMD_MODE_IEEE);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q          <= '0;
      s_q.pktOpt   <= PCMD_RST_PKT_OPT;
      s_q.rxDelay  <= PCMD_RST_RX_DELAY;
      s_q.txDelay  <= PCMD_RST_TX_DELAY;
      s_q.bufCfg   <= PCMD_RST_BUF_CFG;
      s_q.delayExt <= PCMD_RST_DELAY_EXT;
      s_q.mode     <= PCMD_RST_MODE;
      // Checksum levels match the option and mode reset values
      s_q.chkOn    <= !PCMD_RST_PKT_OPT[PCMD_BIT_FCS_OFF];
      s_q.storeRs  <= !PCMD_RST_PKT_OPT[PCMD_BIT_FCS_OFF] &&
                      (PCMD_RST_MODE == PCMD_MODE_IEEE);
      s_q.state    <= IDLE;
    end
    else
      s_q <= s_d;
  end

  // ==========================================================================
  // Outputs, all registered
  assign wb_dat_o       = s_q.datOut;
  assign wb_ack_o       = s_q.ack;
  assign searchStart    = s_q.search;
  assign rssiWindowOpen = s_q.rssiWin;
  assign txEnter        = s_q.txGo;
  assign syntCalRun     = s_q.synt;
  assign irq            = s_q.irqOut;
  assign frameRcvdOk    = s_q.frameOk;
  // Add-on follows its enable bit only
  assign addonEnable    = s_q.pktOpt[PCMD_BIT_ADDON];
  assign autoChkRx      = s_q.chkOn;
  assign autoChkTx      = s_q.chkOn;
  assign storeRssiQuality = s_q.storeRs;

endmodule : pcmd_top

`default_nettype wire

// ---- verification/pcmd_props.sv ----
// Purpose: Port checks for pcmd_top
// Assumes: One clock, async active-low reset
// Notes: Bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module pcmd_props
  import pcmd_pkg::*;
#(
  parameter int CLK_HZ = PCMD_CLK_HZ  // Core clock rate
)(
  input wire logic        core_clk,         // Clock
  input wire logic        arst_n,           // Reset
  input wire logic        wb_cyc_i,         // Cycle
  input wire logic        wb_stb_i,         // Strobe
  input wire logic [31:0] wb_dat_o,         // Read data
  input wire logic        wb_ack_o,         // Ack
  input wire logic        cmdEnterReceive,  // Rx command
  input wire logic        cmdEnterTransmit, // Tx command
  input wire logic        frameDone,        // Frame end
  input wire logic        chkValid,         // Check good
  input wire logic        searchStart,      // Search pulse
  input wire logic        rssiWindowOpen,   // RSSI window
  input wire logic        txEnter,          // Tx pulse
  input wire logic        syntCalRun,       // Calibration
  input wire logic        autoChkRx,        // Rx check on
  input wire logic        autoChkTx,        // Tx check on
  input wire logic        storeRssiQuality, // Overwrite FCS
  input wire logic        frameRcvdOk       // Good frame
);
  // ==========================================
  // Length of the calibration phase in cycles
  localparam int CalCyc = PCMD_SYNT_SETTLE_US * (CLK_HZ / 1_000_000);
  int calCnt_q;
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n) calCnt_q <= 0;
    else calCnt_q <= syntCalRun ? calCnt_q + 1 : 0;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  property p_ackPulse;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("ack not a pulse");
  property p_datIdle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_datIdle: assert property (p_datIdle) else $error("data without ack");
  property p_calLen;
    $fell(syntCalRun) |-> calCnt_q >= CalCyc - 1 && calCnt_q <= CalCyc + 1;
  endproperty
  a_calLen: assert property (p_calLen)
    else $error("settle length");
  property p_calCause;
    $rose(syntCalRun) |-> $past(cmdEnterReceive) || $past(cmdEnterTransmit);
  endproperty
  a_calCause: assert property (p_calCause)
    else $error("stray settle");
  property p_frameOk;
    frameRcvdOk |-> $past(frameDone) &&
                    ($past(chkValid) || !$past(autoChkRx));
  endproperty
  a_frameOk: assert property (p_frameOk)
    else $error("bad frame passed");
  property p_chkPair;
    autoChkRx == autoChkTx && (!storeRssiQuality || autoChkRx);
  endproperty
  a_chkPair: assert property (p_chkPair)
    else $error("check modes split");
  property p_rssiWin;
    $rose(rssiWindowOpen) |-> searchStart;
  endproperty
  a_rssiWin: assert property (p_rssiWin)
    else $error("rssi window early");
  property p_startPulse;
    searchStart || txEnter |-> !syntCalRun && !(searchStart && txEnter)
                               ##1 !searchStart && !txEnter;
  endproperty
  a_startPulse: assert property (p_startPulse)
    else $error("start pulse");
  c_tx: cover property (txEnter);
  c_rx: cover property (searchStart && rssiWindowOpen);
  c_frame: cover property (frameRcvdOk);
endmodule : pcmd_props
bind pcmd_top pcmd_props #(.CLK_HZ(CLK_HZ)) pcmd_props_i (
  .core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .cmdEnterReceive(cmdEnterReceive), .cmdEnterTransmit(cmdEnterTransmit),
  .frameDone(frameDone), .chkValid(chkValid), .searchStart(searchStart),
  .rssiWindowOpen(rssiWindowOpen), .txEnter(txEnter),
  .syntCalRun(syntCalRun), .autoChkRx(autoChkRx), .autoChkTx(autoChkTx),
  .storeRssiQuality(storeRssiQuality), .frameRcvdOk(frameRcvdOk));
`default_nettype wire

// ---- verification/pcmd_radio_model.sv ----
// Purpose: Command and radio side source for pcmd_top
// Assumes: Same clock as the block
// Notes: chkValid toggles outside frames so stale values never match
`timescale 1ns/1ps
`default_nettype none
module pcmd_radio_model (
  input  wire logic core_clk,         // Clock
  input  wire logic goRx,             // Ask receive
  input  wire logic goTx,             // Ask transmit
  input  wire logic goFrame,          // Ask frame end
  input  wire logic crcOk,            // Check result
  output var  logic cmdEnterReceive,  // Rx pulse
  output var  logic cmdEnterTransmit, // Tx pulse
  output var  logic frameDone,        // Frame pulse
  output var  logic chkValid          // Valid with frameDone
);
  // ==========================================
  // Requests reach the outputs one edge later, as long as they are driven
  initial {cmdEnterReceive, cmdEnterTransmit, frameDone, chkValid} = 4'h0;
  always @(posedge core_clk)
  begin
    cmdEnterReceive  <= goRx;
    cmdEnterTransmit <= goTx;
    frameDone        <= goFrame;
    chkValid         <= goFrame ? crcOk : ~chkValid;
  end
endmodule : pcmd_radio_model
`default_nettype wire

// ---- verification/pcmd_tb_top.sv ----
// Purpose: Self-checking bench for pcmd_top
// Assumes: Bench is the Wishbone host
// Notes: One microsecond is C cycles here
`timescale 1ns/1ps
`default_nettype none
module pcmd_tb_top import pcmd_pkg::*;;
  // ==========================================
  // Stimulus, nets and instances
  localparam int C = 2;  // Cycles per microsecond
  logic core_clk = 1'b0, arst_n = 1'b0, wbCyc = 1'b0, wbStb = 1'b0;
  logic wbWe = 1'b0, goRx = 1'b0, goTx = 1'b0, goFrame = 1'b0, crcOk = 1'b0;
  logic [13:0] wbAdr = 14'h0000;
  logic [31:0] wbDat = 32'h00000000, wbRd;
  wire logic [31:0] wbQ;
  wire logic wbAck, cmdRx, cmdTx, frmDone, chkOk, srch, rssiWin, txEn;
  wire logic synt, addon, aChkRx, aChkTx, storeQ, frmOk, irq;
  int mismatches = 0, n_tests = 0;
  initial forever #10 core_clk = ~core_clk;
  pcmd_top #(.CLK_HZ(C * 1_000_000)) pcmd_top_i (
    .core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
    .wb_dat_i(wbDat), .wb_dat_o(wbQ), .wb_ack_o(wbAck),
    .cmdEnterReceive(cmdRx), .cmdEnterTransmit(cmdTx),
    .frameDone(frmDone), .chkValid(chkOk), .searchStart(srch),
    .rssiWindowOpen(rssiWin), .txEnter(txEn), .syntCalRun(synt),
    .addonEnable(addon), .autoChkRx(aChkRx), .autoChkTx(aChkTx),
    .storeRssiQuality(storeQ), .frameRcvdOk(frmOk), .irq(irq));
  pcmd_radio_model pcmd_radio_model_i (.core_clk(core_clk), .goRx(goRx),
    .goTx(goTx), .goFrame(goFrame), .crcOk(crcOk), .cmdEnterReceive(cmdRx),
    .cmdEnterTransmit(cmdTx), .frameDone(frmDone), .chkValid(chkOk));
  // Compare, bus and command tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic near(input int d, input int e, input int tol);
    chk(32'(d >= e - tol && d <= e + tol), 32'h1);
  endtask : near
  task automatic xfer(input logic we, input logic [11:0] idx,
                      input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    {wbCyc, wbStb, wbWe, wbAdr, wbDat} <= {2'b11, we, idx, 2'b00, 24'h0, wd};
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wbAck !== 1'b1 && n < 20);
    wbRd = wbQ;
    {wbCyc, wbStb} <= 2'b00;
    if (n >= 20) chk(32'h0, 32'h1);
  endtask : xfer
  task automatic rd(input logic [11:0] idx, input logic [7:0] e);
    xfer(1'b0, idx, 8'h00);
    chk(wbRd, {24'h0, e});
  endtask : rd
  // Pulse a request, count cycles until the block answers
  task automatic go(input logic [2:0] g, input logic ok, input int lim,
                    output int t);
    t = 0;
    @(posedge core_clk);
    {goFrame, goTx, goRx, crcOk} <= {g, ok};
    @(posedge core_clk);
    {goFrame, goTx, goRx} <= 3'b000;
    while ((srch | txEn | frmOk) !== 1'b1 && t < lim)
    begin
      @(posedge core_clk);
      t++;
    end
  endtask : go
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // Main sequence
  initial
  begin
    int tDis, rDis, t, t16, r;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(PCMD_IDX_PKT_OPT, 8'h04);
    rd(PCMD_IDX_RX_DELAY, 8'hC0);
    rd(PCMD_IDX_TX_DELAY, 8'hC0);
    rd(12'h100, 8'h00);
    xfer(1'b1, PCMD_IDX_PKT_OPT, 8'h15);
    rd(PCMD_IDX_PKT_OPT, 8'h15);
    chk(32'({addon, aChkRx, aChkTx, storeQ}), 32'h8);
    go(3'b100, 1'b0, 6, t);
    chk(32'(t < 6), 32'h1);
    xfer(1'b1, PCMD_IDX_PKT_OPT, 8'h04);
    go(3'b100, 1'b0, 6, t);
    chk(32'(t < 6), 32'h0);
    go(3'b100, 1'b1, 6, t);
    chk(32'(t < 6), 32'h1);
    chk(32'({addon, aChkRx, aChkTx, storeQ}), 32'h7);
    rd(PCMD_IDX_IRQ_STAT, 8'h01);
    xfer(1'b1, PCMD_IDX_IRQ_CLR, 8'h01);
    xfer(1'b1, PCMD_IDX_BUF_CFG, 8'h80);
    go(3'b001, 1'b0, 3000, rDis);
    chk(32'(rssiWin), 32'h1);
    xfer(1'b1, PCMD_IDX_IRQ_EN, 8'h04);
    go(3'b010, 1'b0, 3000, tDis);
    rd(PCMD_IDX_IRQ_STAT, 8'h06);
    chk(32'(irq), 32'h1);
    xfer(1'b1, PCMD_IDX_IRQ_EN, 8'h00);
    rd(PCMD_IDX_IRQ_STAT, 8'h06);
    chk(32'(irq), 32'h0);
    xfer(1'b1, PCMD_IDX_IRQ_CLR, 8'h06);
    rd(PCMD_IDX_IRQ_STAT, 8'h00);
    // Settle phase shows on its pin, then the start pulse follows its end
    go(3'b010, 1'b0, 2, t);
    chk(32'({synt, txEn}), 32'h2);
    go(3'b000, 1'b0, 3000, t);
    near(t, PCMD_SYNT_SETTLE_US * C, 2);
    rd(PCMD_IDX_STATUS, 8'h08);
    xfer(1'b1, PCMD_IDX_BUF_CFG, 8'h00);
    go(3'b010, 1'b0, 3000, t);
    xfer(1'b1, PCMD_IDX_TX_DELAY, 8'h10);
    go(3'b010, 1'b0, 3000, t16);
    near(t - t16, 176 * C, 1);
    near(t16 - tDis, 16 * C, 2);
    xfer(1'b1, PCMD_IDX_DELAY_EXT, 8'h01);
    go(3'b010, 1'b0, 3000, r);
    near(r - t16, 4 * C, 1);
    xfer(1'b1, PCMD_IDX_RX_DELAY, 8'h10);
    go(3'b001, 1'b0, 3000, r);
    near(r - rDis, 20 * C, 2);
    xfer(1'b1, PCMD_IDX_MODE, 8'h04);
    go(3'b001, 1'b0, 3000, t);
    near(t - r, 0, 1);
    chk(32'({rssiWin, storeQ}), 32'h0);
    go(3'b100, 1'b0, 6, t);
    chk(32'(t < 6), 32'h0);
    xfer(1'b1, PCMD_IDX_PKT_OPT, 8'h05);
    go(3'b100, 1'b0, 6, t);
    chk(32'(t < 6), 32'h1);
    // Streaming format is not a packet mode: no frame report
    xfer(1'b1, PCMD_IDX_MODE, 8'h03);
    go(3'b100, 1'b0, 6, t);
    chk(32'(t < 6), 32'h0);
    xfer(1'b1, PCMD_IDX_BUF_CFG, 8'hB0);
    xfer(1'b1, PCMD_IDX_PKT_OPT, 8'h0C);
    go(3'b010, 1'b0, 3000, t);
    near(tDis - t, PCMD_SYNT_SETTLE_US * C, 2);
    xfer(1'b1, PCMD_IDX_PKT_OPT, 8'h04);
    summarize();
  end
  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    summarize();
  end
endmodule : pcmd_tb_top
`default_nettype wire
